// file: rtl/fcms_pkg.sv
package fcms_pkg;

  // Register byte offsets
  localparam logic [11:0] FCMS_CTRL_OFS   = 12'h000;
  localparam logic [11:0] FCMS_STATUS_OFS = 12'h004;
  localparam logic [11:0] FCMS_COUNT_OFS  = 12'h008;

  // Control word field positions
  localparam int FCMS_SRCSEL_LSB  = 0;
  localparam int FCMS_IREFSEL_BIT = 2;
  localparam int FCMS_LOOPSEL_BIT = 3;
  localparam int FCMS_REFDIV_LSB  = 4;

  // Control field codes and reset values
  localparam logic [1:0] FCMS_SRCSEL_FLL     = 2'h0;
  localparam logic [1:0] FCMS_SRCSEL_INTREF  = 2'h1;
  localparam logic [2:0] FCMS_REFDIV_NONE    = 3'h0;
  localparam logic       FCMS_IREFSEL_RESET  = 1'b1;
  localparam logic       FCMS_LOOPSEL_RESET  = 1'b0;
  localparam logic [1:0] FCMS_SRCSEL_RESET   = FCMS_SRCSEL_FLL;
  localparam logic [2:0] FCMS_REFDIV_RESET   = FCMS_REFDIV_NONE;

  // Status word field positions
  localparam int FCMS_STAT_MODE_LSB = 0;
  localparam int FCMS_STAT_PLLOFF   = 4;
  localparam int FCMS_STAT_LOCK     = 5;

  // Loop figures
  localparam logic [15:0] FCMS_FLL_MULT     = 16'h0400;
  localparam logic [15:0] FCMS_LOCK_WINDOW  = 16'h0002;
  localparam logic [23:0] FCMS_DCO_INC_RST  = 24'h226000;
  localparam logic [23:0] FCMS_DCO_INC_STEP = 24'h000100;

  // Control fields written by software
  typedef struct packed {
    logic [2:0] reference_divider;
    logic       phase_loop_select;
    logic       internal_reference_select;
    logic [1:0] clock_source_select;
  } fcms_ctrl_s;

  // Mode machine, one-hot
  typedef enum logic [3:0] {
    ST_ENGAGED_INTERNAL = 4'b0001,
    ST_ENGAGED_EXTERNAL = 4'b0010,
    ST_BYPASSED_INTERNAL = 4'b0100,
    ST_DEFERRED         = 4'b1000
  } fcms_mode_e;

endpackage

// file: rtl/fcms_top.sv
`timescale 1ns/1ps
module fcms_top
  import fcms_pkg::*;
(
  input  wire logic        REF_CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        INT_REF_IN,
  input  wire logic        EXT_REF_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  output logic             GEN_OUT_CLK_OUT,
  output logic             GEN_LOWRATE_CLK_OUT,
  output logic             PLL_POWERDOWN_OUT,
  output logic             FLL_ENABLE_OUT,
  output logic [3:0]       MODE_OUT
);

  fcms_ctrl_s  ctrl;
  fcms_mode_e  mode;
  fcms_mode_e  next_mode;
  logic [1:0]  int_sync;
  logic [1:0]  ext_sync;
  logic        ref_prev;
  logic        ref_rise;
  logic        ref_sel;
  logic [6:0]  div_cnt;
  logic        ref_tick;
  logic [23:0] dco_acc;
  logic [23:0] dco_inc;
  logic        dco_prev;
  logic        dco_rise;
  logic [15:0] dco_cnt;
  logic [15:0] last_cnt;
  logic        locked;
  logic        setup;
  logic        addr_ok;
  logic        wr_en;
  logic        engaged;

  // Pins from the reference oscillators cross in through two flops each
  always_ff @(posedge REF_CLK_IN) begin
    int_sync <= {int_sync[0], INT_REF_IN};
    ext_sync <= {ext_sync[0], EXT_REF_IN};
  end

  // Reference chosen by the internal select bit, edge taken after synchroniser
  assign ref_sel  = ctrl.internal_reference_select ? int_sync[1] : ext_sync[1];
  assign ref_rise = ref_sel & ~ref_prev;

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      ref_prev <= 1'b0;
    end else begin
      ref_prev <= ref_sel;
    end
  end

  // Divider by two to the power of the field; tick marks one divided period
  assign ref_tick = ref_rise && (div_cnt == 7'((8'h01 << ctrl.reference_divider) - 8'h01));

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      div_cnt <= 7'h00;
    end else if (ref_tick) begin
      div_cnt <= 7'h00;
    end else if (ref_rise) begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  // Digital oscillator: a phase accumulator whose top bit is the FLL clock
  // Gated by the enable: a frozen accumulator would otherwise count an edge every cycle
  assign dco_rise = FLL_ENABLE_OUT & dco_acc[23] & ~dco_prev;

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      dco_acc  <= 24'h000000;
      dco_prev <= 1'b0;
    end else if (FLL_ENABLE_OUT) begin
      dco_acc  <= dco_acc + dco_inc;
      dco_prev <= dco_acc[23];
    end
  end

  // Count oscillator edges per divided reference period
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      dco_cnt  <= 16'h0000;
      last_cnt <= 16'h0000;
    end else if (ref_tick) begin
      dco_cnt  <= {15'h0000, dco_rise};
      last_cnt <= dco_cnt;
    end else if (dco_rise && dco_cnt != 16'hFFFF) begin
      dco_cnt <= dco_cnt + 16'h0001;
    end
  end

  // Frequency loop: nudge the increment so each period holds 1024 edges.
  // The FLL keeps tracking in bypassed mode too, so a later engage is quick.
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      dco_inc <= FCMS_DCO_INC_RST;
    end else if (ref_tick && FLL_ENABLE_OUT) begin
      if (dco_cnt < FCMS_FLL_MULT) begin
        dco_inc <= dco_inc + FCMS_DCO_INC_STEP;
      end else if (dco_cnt > FCMS_FLL_MULT) begin
        dco_inc <= dco_inc - FCMS_DCO_INC_STEP;
      end
    end
  end

  // Lock flag within a small window around the target
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      locked <= 1'b0;
    end else if (ref_tick) begin
      locked <= (dco_cnt >= FCMS_FLL_MULT - FCMS_LOCK_WINDOW) &&
                (dco_cnt <= FCMS_FLL_MULT + FCMS_LOCK_WINDOW);
    end
  end

  // Mode decode; any combination outside the three is left to outer logic
  always_comb begin
    next_mode = ST_DEFERRED;
    if (ctrl.clock_source_select == FCMS_SRCSEL_FLL && ctrl.internal_reference_select &&
        !ctrl.phase_loop_select && ctrl.reference_divider == FCMS_REFDIV_NONE) begin
      next_mode = ST_ENGAGED_INTERNAL;
    end else if (ctrl.clock_source_select == FCMS_SRCSEL_FLL &&
                 !ctrl.internal_reference_select && !ctrl.phase_loop_select) begin
      next_mode = ST_ENGAGED_EXTERNAL;
    end else if (ctrl.clock_source_select == FCMS_SRCSEL_INTREF &&
                 ctrl.internal_reference_select && !ctrl.phase_loop_select &&
                 ctrl.reference_divider == FCMS_REFDIV_NONE) begin
      next_mode = ST_BYPASSED_INTERNAL;
    end
  end

  // Mode machine; every state may move to any decoded mode
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      mode <= ST_ENGAGED_INTERNAL;
    end else begin
      unique case (mode)
        ST_ENGAGED_INTERNAL:  mode <= next_mode;
        ST_ENGAGED_EXTERNAL:  mode <= next_mode;
        ST_BYPASSED_INTERNAL: mode <= next_mode;
        ST_DEFERRED:          mode <= next_mode;
        default:              mode <= ST_DEFERRED;
      endcase
    end
  end

  assign engaged = (mode == ST_ENGAGED_INTERNAL) || (mode == ST_ENGAGED_EXTERNAL);

  // Clock routing, registered so the outputs never glitch on a mode change
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      GEN_OUT_CLK_OUT     <= 1'b0;
      GEN_LOWRATE_CLK_OUT <= 1'b0;
      PLL_POWERDOWN_OUT   <= 1'b1;
      FLL_ENABLE_OUT      <= 1'b1;
      MODE_OUT            <= ST_ENGAGED_INTERNAL;
    end else begin
      MODE_OUT          <= mode;
      PLL_POWERDOWN_OUT <= engaged;
      FLL_ENABLE_OUT    <= engaged || (mode == ST_BYPASSED_INTERNAL);
      if (engaged) begin
        GEN_OUT_CLK_OUT     <= dco_acc[23];
        GEN_LOWRATE_CLK_OUT <= dco_acc[23];
      end else if (mode == ST_BYPASSED_INTERNAL) begin
        GEN_OUT_CLK_OUT     <= int_sync[1];
        GEN_LOWRATE_CLK_OUT <= 1'b0;
      end else begin
        GEN_OUT_CLK_OUT     <= 1'b0;
        GEN_LOWRATE_CLK_OUT <= 1'b0;
      end
    end
  end

  // APB decode: zero wait states, error on unmapped word
  assign setup   = PSEL_IN && !PENABLE_IN;
  assign addr_ok = (PADDR_IN == FCMS_CTRL_OFS) || (PADDR_IN == FCMS_STATUS_OFS) ||
                   (PADDR_IN == FCMS_COUNT_OFS);
  assign wr_en   = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == FCMS_CTRL_OFS;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_ok;

  // Control register; only the low byte lane carries fields
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      ctrl.clock_source_select       <= FCMS_SRCSEL_RESET;
      ctrl.internal_reference_select <= FCMS_IREFSEL_RESET;
      ctrl.phase_loop_select         <= FCMS_LOOPSEL_RESET;
      ctrl.reference_divider         <= FCMS_REFDIV_RESET;
    end else if (wr_en && PSTRB_IN[0]) begin
      ctrl.clock_source_select       <= PWDATA_IN[FCMS_SRCSEL_LSB +: 2];
      ctrl.internal_reference_select <= PWDATA_IN[FCMS_IREFSEL_BIT];
      ctrl.phase_loop_select         <= PWDATA_IN[FCMS_LOOPSEL_BIT];
      ctrl.reference_divider         <= PWDATA_IN[FCMS_REFDIV_LSB +: 3];
    end
  end

  // Read data captured in the setup cycle, held through the access
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      PRDATA_OUT <= 32'h00000000;
    end else if (setup) begin
      PRDATA_OUT <= 32'h00000000;
      if (PADDR_IN == FCMS_CTRL_OFS) begin
        PRDATA_OUT[6:0] <= ctrl;
      end else if (PADDR_IN == FCMS_STATUS_OFS) begin
        PRDATA_OUT[FCMS_STAT_MODE_LSB +: 4] <= mode;
        PRDATA_OUT[FCMS_STAT_PLLOFF]        <= PLL_POWERDOWN_OUT;
        PRDATA_OUT[FCMS_STAT_LOCK]          <= locked;
      end else if (PADDR_IN == FCMS_COUNT_OFS) begin
        PRDATA_OUT[15:0] <= last_cnt;
      end
    end
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  reset_mode_a: assert property ($fell(SYS_RST_IN) |-> MODE_OUT == ST_ENGAGED_INTERNAL)
    else $error("mode after reset is not engaged internal");

  // Checks sit together after all the logic they guard; all run on the system clock.
  // Reset masks them, so the first checked edge is the one after release.
  decode_int_a: assert property (
    (ctrl.clock_source_select == FCMS_SRCSEL_FLL && ctrl.internal_reference_select &&
     !ctrl.phase_loop_select && ctrl.reference_divider == FCMS_REFDIV_NONE)
    |=> mode == ST_ENGAGED_INTERNAL)
    else $error("engaged internal fields not decoded");

  lowrate_fll_a: assert property (
    mode == ST_ENGAGED_INTERNAL |=> GEN_LOWRATE_CLK_OUT == $past(dco_acc[23]))
    else $error("low-rate clock not taken from FLL");

  out_from_fll_a: assert property (
    mode == ST_ENGAGED_INTERNAL |=> GEN_OUT_CLK_OUT == $past(dco_acc[23]))
    else $error("output clock not taken from FLL");

  loop_dir_a: assert property (
    (ref_tick && FLL_ENABLE_OUT && dco_cnt < FCMS_FLL_MULT) |=> dco_inc > $past(dco_inc))
    else $error("FLL did not speed up below target");

  loop_down_a: assert property (
    (ref_tick && FLL_ENABLE_OUT && dco_cnt > FCMS_FLL_MULT) |=> dco_inc < $past(dco_inc))
    else $error("FLL did not slow down above target");

  pll_off_a: assert property (engaged |=> PLL_POWERDOWN_OUT && FLL_ENABLE_OUT)
    else $error("PLL not held off while engaged");

  decode_ext_a: assert property (
    (ctrl.clock_source_select == FCMS_SRCSEL_FLL && !ctrl.internal_reference_select &&
     !ctrl.phase_loop_select) |=> mode == ST_ENGAGED_EXTERNAL)
    else $error("engaged external fields not decoded");

  ext_out_a: assert property (
    mode == ST_ENGAGED_EXTERNAL |=> GEN_OUT_CLK_OUT == $past(dco_acc[23]) &&
    GEN_LOWRATE_CLK_OUT == GEN_OUT_CLK_OUT)
    else $error("external mode clocks not both from FLL");

  bypass_out_a: assert property (
    mode == ST_BYPASSED_INTERNAL |=> GEN_OUT_CLK_OUT == $past(int_sync[1]) && FLL_ENABLE_OUT)
    else $error("bypassed output not from internal reference");

  decode_byp_a: assert property (
    (ctrl.clock_source_select == FCMS_SRCSEL_INTREF && ctrl.internal_reference_select &&
     !ctrl.phase_loop_select && ctrl.reference_divider == FCMS_REFDIV_NONE)
    ##1 (ctrl == $past(ctrl)) |-> mode == ST_BYPASSED_INTERNAL)
    else $error("bypassed internal fields not decoded");

  mode_onehot_a: assert property ($onehot(mode))
    else $error("mode is not one-hot");

  defer_idle_a: assert property (
    mode == ST_DEFERRED |=> !GEN_OUT_CLK_OUT && !GEN_LOWRATE_CLK_OUT)
    else $error("deferred mode still drives clocks");

  defer_loop_a: assert property (
    mode == ST_DEFERRED |=> !FLL_ENABLE_OUT)
    else $error("deferred mode still runs the FLL");

endmodule // fcms_top

// file: bench/fcms_ref_src.sv
`timescale 1ns/1ps
// Free-running internal and external reference oscillators
module fcms_ref_src #(
  parameter real INT_HALF_NS = 15259.0,
  parameter real EXT_HALF_NS = 3815.0
) (
  output logic int_ref_out,
  output logic ext_ref_out
);
  // Odd start offsets keep both sources unrelated in phase to the system clock
  initial begin
    int_ref_out = 1'b0;
    #1.3;
    forever #(INT_HALF_NS) int_ref_out = ~int_ref_out;
  end
  // Four times faster, so a divide by four lands in the same band as internal
  initial begin
    ext_ref_out = 1'b0;
    #2.7;
    forever #(EXT_HALF_NS) ext_ref_out = ~ext_ref_out;
  end
endmodule // fcms_ref_src

// file: bench/fll_clock_mode_select_tb.sv
`timescale 1ns/1ps
module fll_clock_mode_select_tb;
  import fcms_pkg::*;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        gen_clk;
  logic        low_clk;
  logic        pll_off;
  logic        fll_en;
  logic [3:0]  mode;
  logic        int_ref;
  logic        ext_ref;
  logic [31:0] rdat;
  logic [31:0] ng;
  logic [31:0] nl;
  logic [31:0] ni;
  int          num_errors;
  int          checks_done;

  fcms_ref_src u_fcms_ref_src (.int_ref_out(int_ref), .ext_ref_out(ext_ref));

  fcms_top u_fcms_top (
    .REF_CLK_IN(clk), .SYS_RST_IN(rst), .INT_REF_IN(int_ref), .EXT_REF_IN(ext_ref),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .GEN_OUT_CLK_OUT(gen_clk), .GEN_LOWRATE_CLK_OUT(low_clk),
    .PLL_POWERDOWN_OUT(pll_off), .FLL_ENABLE_OUT(fll_en), .MODE_OUT(mode));

  task automatic conclude();
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic rng(input logic [31:0] got, lo, hi, input string what);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s got %0d", $time, what, got);
    end
  endtask

  // One APB transfer; every access also checks the error flag against the map
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    chk({31'h0, pslverr}, {31'h0, a > FCMS_COUNT_OFS}, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Rising edges of both generated clocks and of the internal reference
  task automatic measure(input int cyc);
    logic pg, pl, pi;
    ng = 0;
    nl = 0;
    ni = 0;
    {pg, pl, pi} = {gen_clk, low_clk, int_ref};
    repeat (cyc) begin
      @(posedge clk);
      ng = ng + {31'h0, gen_clk && !pg};
      nl = nl + {31'h0, low_clk && !pl};
      ni = ni + {31'h0, int_ref && !pi};
      {pg, pl, pi} = {gen_clk, low_clk, int_ref};
    end
  endtask

  task automatic t_reset();
    chk({28'h0, mode}, 32'h1, "reset mode");
    chk({30'h0, pll_off, fll_en}, 32'h3, "reset loop enables");
    apb(1'b0, FCMS_CTRL_OFS, 32'h0, rdat);
    chk(rdat, 32'h4, "reset ctrl");
  endtask

  // Poll at least three reference periods so a stale count from the old mode is gone
  task automatic t_lock(input logic [31:0] ctl);
    int n;
    apb(1'b1, FCMS_CTRL_OFS, ctl, rdat);
    n = 0;
    do begin
      repeat (1000) @(posedge clk);
      apb(1'b0, FCMS_STATUS_OFS, 32'h0, rdat);
      n++;
    end while (n < 24 || (rdat[FCMS_STAT_LOCK] !== 1'b1 && n < 60));
    chk({31'h0, rdat[FCMS_STAT_LOCK]}, 32'h1, "loop lock");
    apb(1'b0, FCMS_COUNT_OFS, 32'h0, rdat);
    rng(rdat, 1022, 1026, "loop count");
    measure(1000);
    rng(ng, 125, 145, "output clock rate");
    rng(nl, 1, 1000, "low-rate clock");
    chk({30'h0, pll_off, fll_en}, 32'h3, "pll held off");
  endtask

  task automatic t_decode();
    logic [31:0] ctl [8] = '{32'h04, 32'h00, 32'h30, 32'h05, 32'h14, 32'h0C, 32'h01, 32'h06};
    logic [3:0]  exp [8] = '{4'h1, 4'h2, 4'h2, 4'h4, 4'h8, 4'h8, 4'h8, 4'h8};
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, FCMS_CTRL_OFS, ctl[i], rdat);
      repeat (3) @(posedge clk);
      chk({28'h0, mode}, {28'h0, exp[i]}, "mode select");
      chk({31'h0, fll_en}, {31'h0, exp[i] != 4'h8}, "loop enable");
      apb(1'b0, FCMS_STATUS_OFS, 32'h0, rdat);
      chk({28'h0, rdat[3:0]}, {28'h0, exp[i]}, "status mode");
      apb(1'b0, FCMS_CTRL_OFS, 32'h0, rdat);
      chk(rdat, ctl[i], "ctrl readback");
    end
    measure(500);
    rng(ng + nl, 0, 0, "deferred clocks idle");
  endtask

  // Unmapped, strobe-less and read-only writes must all leave ctrl alone
  task automatic t_refused();
    apb(1'b0, 12'h00C, 32'h0, rdat);
    chk(rdat, 32'h0, "unmapped read");
    pstrb <= 4'h0;
    apb(1'b1, FCMS_CTRL_OFS, 32'h05, rdat);
    pstrb <= 4'hF;
    apb(1'b1, FCMS_STATUS_OFS, 32'h0, rdat);
    apb(1'b1, 12'h00C, 32'h05, rdat);
    apb(1'b0, FCMS_CTRL_OFS, 32'h0, rdat);
    chk(rdat, 32'h06, "ctrl kept");
  endtask

  task automatic t_bypass();
    apb(1'b1, FCMS_CTRL_OFS, 32'h05, rdat);
    repeat (3) @(posedge clk);
    measure(16000);
    rng(ng, ni - 1, ni + 1, "bypass output edges");
    rng(nl, 0, 0, "bypass low-rate idle");
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 44'h0, 4'hF};
    num_errors = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_lock(32'h04);
    t_decode();
    t_refused();
    t_bypass();
    t_lock(32'h20);
    conclude();
  end
endmodule // fll_clock_mode_select_tb
